// [hw/rtp_consts.svh]
`ifndef RTP_CONSTS_SVH
`define RTP_CONSTS_SVH

// ****************************************
// register indices (byte address = index * 4)
// ****************************************
`define RTP_IDX_RUN    10'h108
`define RTP_IDX_OSC    10'h109
`define RTP_IDX_PIN    10'h10A
`define RTP_IDX_MODE   10'h10B
`define RTP_IDX_PRE    10'h10C
`define RTP_IDX_SEC    10'h10D
`define RTP_IDX_PRI    10'h10E
`define RTP_IDX_ROUTE  10'h181

// ****************************************
// field positions
// ****************************************
`define RTP_B_RUN      0
`define RTP_B_CACT     1
`define RTP_B_HALT     2
`define RTP_B_TRIG     0
`define RTP_B_OSHALT   1
`define RTP_B_SPACT    2
`define RTP_B_POLICY   3
`define RTP_B_SRC_LO   4
`define RTP_B_SRC_HI   5
`define RTP_B_GATE     7
`define RTP_B_AUX      5

// ****************************************
// reset values and widths
// ****************************************
`define RTP_CNT_RST    8'hFF
`define RTP_REG_ZERO   8'h00
`define RTP_DIV_F8     3'h7
`define RTP_PIN_W      4
`define RTP_ROUTE_P0   2'h0
`define RTP_ROUTE_P1   2'h1

`endif

// [hw/rtp_pkg.sv]
package rtp_pkg;

  typedef enum logic [1:0] {
    RTP_MODE_TIMER,
    RTP_MODE_WAVE,
    RTP_MODE_ONESHOT,
    RTP_MODE_WAITSHOT
  } rtp_mode_t;

  typedef enum logic [1:0] {
    RTP_SRC_F1,
    RTP_SRC_F8,
    RTP_SRC_NEIGHBOR,
    RTP_SRC_F2
  } rtp_src_t;

  typedef enum logic {
    RTP_PH_PRIMARY,
    RTP_PH_SECONDARY
  } rtp_phase_t;

  typedef struct packed {
    logic       run;
    logic       cact;
    logic       spact;
    rtp_mode_t  mode;
    logic       policy;
    rtp_src_t   src;
    logic       gate;
    logic [3:0] lvl;
    logic [1:0] route;
    logic       aux;
    logic [7:0] pre_rl;
    logic [7:0] pre_cnt;
    logic [7:0] pri_rl;
    logic [7:0] sec_rl;
    logic [7:0] tmr_cnt;
    rtp_phase_t phase;
    logic       pend_pre;
    logic       pend_tmr;
    logic [2:0] div;
    logic       pulse;
    logic [1:0] pins;
    logic       wait_rq;
    logic [7:0] rdata;
  } rtp_state_t;

endpackage

// [hw/rtp_timer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rtp_consts.svh"

// Contract
// - 8-bit prescaler feeds 8-bit timer; each has reload and counter.
// - timer has primary and secondary reload values, both loadable.
// - mode field: 00 timer, 01 waveform, 10 one-shot, 11 wait one-shot.
// - run bit starts/stops; active flag shows counting or accepted trigger.
// - force halt stops, reads 0, resets reloads to FFh, clears flags.
// - trigger bit starts a one-shot and reads 0.
// - one-shot halt bit stops one-shot counting and reads 0.
// - one-shot active flag is 1 while one-shot runs, wait included.
// - one-shot control acts only in the two one-shot modes.
// - write policy 0 loads reload and counter while counting; 1 reload only.
// - source select: f1, f8, neighbour underflow, f2.
// - gate bit 1 blocks the count source.
// - secondary is write-only; used in waveform and wait one-shot modes.
// - primary counts period, one-shot width or wait; readable and writable.
// - primary reads return the live timer count.
// - route field: pin 0, pin 1, unused; code 10 forbidden.
// - waveform reloads primary and secondary alternately, primary first.
// - timer mode reloads primary on timer underflow.
// - counter transfers follow count source and prescaler underflow.
module rtp_timer
  import rtp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        neighbor_underflow_i,
  output logic      [1:0]  pulse_out_pin_o
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
    reg_hit = (addr[11:2] == idx) && (addr[1:0] == 2'h0);
  endfunction

  function automatic logic is_oneshot(input rtp_mode_t m);
    is_oneshot = (m == RTP_MODE_ONESHOT) || (m == RTP_MODE_WAITSHOT);
  endfunction

  rtp_state_t s_reg;
  rtp_state_t s_next;

  logic       wr_go;
  logic       rd_go;
  logic [7:0] wd;
  logic       tick;
  logic       running;
  logic       pre_uf;
  logic       tmr_uf;
  logic       idle;
  logic       level;

  // a write lands only at the edge where waitrequest is low and lane 0 is enabled
  assign wr_go = avs_write_i && !s_reg.wait_rq && avs_byteenable_i[0];
  assign rd_go = avs_read_i && s_reg.wait_rq;
  assign wd    = avs_writedata_i[7:0];
  assign idle  = !s_reg.cact && !s_reg.spact;

  // ****************************************
  // count source
  // ****************************************
  always_comb begin
    unique case (s_reg.src)
      RTP_SRC_F1:       tick = 1'b1;
      RTP_SRC_F8:       tick = (s_reg.div == `RTP_DIV_F8);
      RTP_SRC_NEIGHBOR: tick = neighbor_underflow_i;
      RTP_SRC_F2:       tick = s_reg.div[0];
    endcase
    if (s_reg.gate) begin
      tick = 1'b0;
    end
  end

  // one-shot modes count only while the one-shot is active, wait included; others while active
  assign running = is_oneshot(s_reg.mode) ? s_reg.spact : s_reg.cact;
  // prescaler underflow drives the timer stage
  assign pre_uf  = running && tick && !s_reg.pend_pre && (s_reg.pre_cnt == `RTP_REG_ZERO);
  assign tmr_uf  = pre_uf && !s_reg.pend_tmr && (s_reg.tmr_cnt == `RTP_REG_ZERO);
  assign level   = s_reg.pulse ^ s_reg.lvl[0];

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    s_next     = s_reg;
    s_next.div = s_reg.div + 3'h1;

    // active flag follows run in timer and waveform modes
    if (!is_oneshot(s_reg.mode)) begin
      if (!s_reg.run) begin
        s_next.cact = 1'b0;
      end else if (tick && !s_reg.cact) begin
        s_next.cact  = 1'b1;
        s_next.phase = RTP_PH_PRIMARY;
        s_next.pulse = 1'b0;
      end
    end else if (!s_reg.run) begin
      s_next.cact  = 1'b0;
      s_next.spact = 1'b0;
      s_next.pulse = 1'b0;
    end

    // prescaler transfers in step with the count source
    if (running && tick) begin
      if (s_reg.pend_pre) begin
        s_next.pre_cnt  = s_reg.pre_rl;
        s_next.pend_pre = 1'b0;
      end else if (s_reg.pre_cnt == `RTP_REG_ZERO) begin
        s_next.pre_cnt = s_reg.pre_rl;
      end else begin
        s_next.pre_cnt = s_reg.pre_cnt - 8'h01;
      end
    end

    // timer transfers in step with prescaler underflow
    if (pre_uf) begin
      if (s_reg.pend_tmr) begin
        s_next.tmr_cnt  = s_reg.pri_rl;
        s_next.pend_tmr = 1'b0;
      end else if (!tmr_uf) begin
        s_next.tmr_cnt = s_reg.tmr_cnt - 8'h01;
      end
    end

    if (tmr_uf) begin
      unique case (s_reg.mode)
        RTP_MODE_TIMER: begin
          s_next.tmr_cnt = s_reg.pri_rl;
        end
        RTP_MODE_WAVE: begin
          s_next.pulse = !s_reg.pulse;
          if (s_reg.phase == RTP_PH_PRIMARY) begin
            s_next.phase   = RTP_PH_SECONDARY;
            s_next.tmr_cnt = s_reg.sec_rl;
          end else begin
            s_next.phase   = RTP_PH_PRIMARY;
            s_next.tmr_cnt = s_reg.pri_rl;
          end
        end
        RTP_MODE_ONESHOT: begin
          s_next.spact   = 1'b0;
          s_next.pulse   = 1'b0;
          s_next.tmr_cnt = s_reg.pri_rl;
        end
        RTP_MODE_WAITSHOT: begin
          // secondary sets the width after the primary wait
          if (s_reg.phase == RTP_PH_PRIMARY) begin
            s_next.phase   = RTP_PH_SECONDARY;
            s_next.tmr_cnt = s_reg.sec_rl;
            s_next.pulse   = 1'b1;
          end else begin
            s_next.phase   = RTP_PH_PRIMARY;
            s_next.spact   = 1'b0;
            s_next.pulse   = 1'b0;
            s_next.tmr_cnt = s_reg.pri_rl;
          end
        end
      endcase
    end

    // ****************************************
    // bus writes
    // ****************************************
    if (wr_go) begin
      if (reg_hit(avs_address_i, `RTP_IDX_RUN)) begin
        s_next.run = wd[`RTP_B_RUN];
        // force halt restores counters and clears flags
        if (wd[`RTP_B_HALT]) begin
          s_next.run      = 1'b0;
          s_next.cact     = 1'b0;
          s_next.spact    = 1'b0;
          s_next.pulse    = 1'b0;
          s_next.phase    = RTP_PH_PRIMARY;
          s_next.pend_pre = 1'b0;
          s_next.pend_tmr = 1'b0;
          s_next.pre_rl   = `RTP_CNT_RST;
          s_next.pre_cnt  = `RTP_CNT_RST;
          s_next.pri_rl   = `RTP_CNT_RST;
          s_next.sec_rl   = `RTP_CNT_RST;
          s_next.tmr_cnt  = `RTP_CNT_RST;
        end
      end
      // one-shot control only in one-shot modes
      if (reg_hit(avs_address_i, `RTP_IDX_OSC) && is_oneshot(s_reg.mode)) begin
        // trigger starts from primary when run is set and the one-shot is inactive
        if (wd[`RTP_B_TRIG] && s_reg.run && !s_reg.spact) begin
          s_next.cact     = 1'b1;
          s_next.spact    = 1'b1;
          s_next.phase    = RTP_PH_PRIMARY;
          s_next.pre_cnt  = s_reg.pre_rl;
          s_next.tmr_cnt  = s_reg.pri_rl;
          s_next.pend_pre = 1'b0;
          s_next.pend_tmr = 1'b0;
          s_next.pulse    = (s_reg.mode == RTP_MODE_ONESHOT);
        end
        if (wd[`RTP_B_OSHALT]) begin
          s_next.spact = 1'b0;
          s_next.pulse = 1'b0;
        end
      end
      if (reg_hit(avs_address_i, `RTP_IDX_PIN)) begin
        s_next.lvl = wd[`RTP_PIN_W-1:0];
      end
      if (reg_hit(avs_address_i, `RTP_IDX_MODE)) begin
        s_next.mode   = rtp_mode_t'(wd[1:0]);
        s_next.policy = wd[`RTP_B_POLICY];
        s_next.src    = rtp_src_t'(wd[`RTP_B_SRC_HI:`RTP_B_SRC_LO]);
        s_next.gate   = wd[`RTP_B_GATE];
      end
      // policy decides whether a busy write reaches the counter
      if (reg_hit(avs_address_i, `RTP_IDX_PRE)) begin
        s_next.pre_rl = wd;
        if (idle) begin
          s_next.pre_cnt = wd;
        end else if (!s_reg.policy) begin
          s_next.pend_pre = 1'b1;
        end
      end
      if (reg_hit(avs_address_i, `RTP_IDX_SEC)) begin
        s_next.sec_rl = wd;
      end
      if (reg_hit(avs_address_i, `RTP_IDX_PRI)) begin
        s_next.pri_rl = wd;
        if (idle) begin
          s_next.tmr_cnt = wd;
        end else if (!s_reg.policy) begin
          s_next.pend_tmr = 1'b1;
        end
      end
      if (reg_hit(avs_address_i, `RTP_IDX_ROUTE)) begin
        s_next.route = wd[1:0];
        s_next.aux   = wd[`RTP_B_AUX];
      end
    end

    // ****************************************
    // bus reads and handshake
    // ****************************************
    // one wait cycle per access: read data are caught while waitrequest is high, writes land when it is low
    s_next.wait_rq = !((avs_read_i || avs_write_i) && s_reg.wait_rq);
    if (rd_go) begin
      s_next.rdata = `RTP_REG_ZERO;
      if (reg_hit(avs_address_i, `RTP_IDX_RUN)) begin
        s_next.rdata[`RTP_B_RUN]  = s_reg.run;
        s_next.rdata[`RTP_B_CACT] = s_reg.cact;
      end
      if (reg_hit(avs_address_i, `RTP_IDX_OSC)) begin
        s_next.rdata[`RTP_B_SPACT] = s_reg.spact;
      end
      if (reg_hit(avs_address_i, `RTP_IDX_PIN)) begin
        s_next.rdata[`RTP_PIN_W-1:0] = s_reg.lvl;
      end
      if (reg_hit(avs_address_i, `RTP_IDX_MODE)) begin
        s_next.rdata[1:0]                         = s_reg.mode;
        s_next.rdata[`RTP_B_POLICY]               = s_reg.policy;
        s_next.rdata[`RTP_B_SRC_HI:`RTP_B_SRC_LO] = s_reg.src;
        s_next.rdata[`RTP_B_GATE]                 = s_reg.gate;
      end
      if (reg_hit(avs_address_i, `RTP_IDX_PRE)) begin
        s_next.rdata = s_reg.pre_cnt;
      end
      // live timer count, also during the secondary period
      if (reg_hit(avs_address_i, `RTP_IDX_PRI)) begin
        s_next.rdata = s_reg.tmr_cnt;
      end
      if (reg_hit(avs_address_i, `RTP_IDX_ROUTE)) begin
        s_next.rdata[1:0]        = s_reg.route;
        s_next.rdata[`RTP_B_AUX] = s_reg.aux;
      end
    end

    // ****************************************
    // pin routing
    // ****************************************
    // forbidden code 10 behaves as unused, so no pin is ever driven twice
    for (int p = 0; p < 2; p++) begin
      s_next.pins[p] = (s_reg.route == 2'(p)) && (s_reg.mode != RTP_MODE_TIMER) && level;
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      s_reg          <= '0;
      s_reg.pre_rl   <= `RTP_CNT_RST;
      s_reg.pre_cnt  <= `RTP_CNT_RST;
      s_reg.pri_rl   <= `RTP_CNT_RST;
      s_reg.sec_rl   <= `RTP_CNT_RST;
      s_reg.tmr_cnt  <= `RTP_CNT_RST;
      s_reg.wait_rq  <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign avs_readdata_o    = {24'h000000, s_reg.rdata};
  assign avs_waitrequest_o = s_reg.wait_rq;
  assign pulse_out_pin_o   = s_reg.pins;

endmodule

`default_nettype wire

// [dv/rtp_checker.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rtp_consts.svh"
module rtp_checker (
  input wire logic        clk_i,
  input wire logic        resetn_i,
  input wire logic [11:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [1:0]  pulse_out_pin_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  // a read that is seen this cycle, answered at the next edge
  sequence s_rd(logic [9:0] idx);
    avs_read_i && avs_waitrequest_o && avs_address_i == {idx, 2'h0};
  endsequence
  a_one_wait: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest not low one cycle after request");
  a_wait_short: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_rd_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data lanes not zero");
  a_misalign_zero: assert property (avs_read_i && avs_waitrequest_o && avs_address_i[1:0] != 2'h0 |=>
    avs_readdata_o == 32'h0) else $error("misaligned read not zero");
  a_sec_hidden: assert property (s_rd(`RTP_IDX_SEC) |=> avs_readdata_o == 32'h0)
    else $error("secondary reload readable");
  a_shot_bits: assert property (s_rd(`RTP_IDX_OSC) |=> avs_readdata_o[7:3] == 5'h0 &&
    avs_readdata_o[1:0] == 2'h0) else $error("one-shot command bits read nonzero");
  a_halt_bit: assert property (s_rd(`RTP_IDX_RUN) |=> avs_readdata_o[7:2] == 6'h0)
    else $error("force halt bit read nonzero");
  a_mode_gaps: assert property (s_rd(`RTP_IDX_MODE) |=> !avs_readdata_o[2] && !avs_readdata_o[6])
    else $error("mode register gap bits nonzero");
  a_one_pin: assert property (!(&pulse_out_pin_o))
    else $error("pulse on both pins");
endmodule
bind rtp_timer rtp_checker u_chk (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .pulse_out_pin_o(pulse_out_pin_o));
`default_nettype wire

// [dv/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
`include "rtp_consts.svh"
module tb_top;
  logic        clk = 1'h0;
  logic        resetn = 1'h0;
  logic [11:0] addr = 12'h0;
  logic        rd = 1'h0;
  logic        wr = 1'h0;
  logic [31:0] wdata = 32'h0;
  logic [3:0]  be = 4'hF;
  logic        nbr = 1'h0;
  logic [1:0]  nct = 2'h0;
  logic [31:0] rdata;
  logic        wt;
  logic [1:0]  pins;
  logic        rt = 1'h0;
  int          failures = 0;
  int          total_checks = 0;
  always #12.5 clk = ~clk;
  // neighbour underflow: one-cycle pulse every fourth clock, as a neighbour in timer mode would give
  // neighbour timer mode
  always @(posedge clk) begin
    nct <= nct + 2'h1;
    nbr <= (nct == 2'h3);
  end
  rtp_timer u_dut (.clk_i(clk), .resetn_i(resetn), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wt), .neighbor_underflow_i(nbr), .pulse_out_pin_o(pins));
  // ****************
  // bus and checks
  // ****************
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s exp %h got %h", nm, e, g);
    end
  endtask
  // entered just after an edge; leaves one idle edge so the next request is a fresh assignment
  task automatic acc(input logic w, input logic [11:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    n = 0;
    addr <= a;
    wdata <= {24'h0, d};
    rd <= !w;
    wr <= w;
    do begin
      @(posedge clk);
      n++;
    end while (wt !== 1'h0 && n < 50);
    q = rdata[7:0];
    rd <= 1'h0;
    wr <= 1'h0;
    if (n >= 50) begin
      failures++;
      end_sim();
    end
    @(posedge clk);
  endtask
  task automatic w8(input logic [9:0] i, input logic [7:0] d);
    logic [7:0] q;
    acc(1'h1, {i, 2'h0}, d, q);
  endtask
  task automatic r8(input logic [9:0] i, input logic [7:0] e);
    logic [7:0] q;
    acc(1'h0, {i, 2'h0}, 8'h0, q);
    chk($sformatf("reg %h", i), e, q);
  endtask
  task automatic gap(output int n, input int lim);
    logic p;
    n = 0;
    p = pins[rt];
    do begin
      @(posedge clk);
      n++;
    end while (pins[rt] === p && n < lim);
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    end_sim();
  end
  // ****************
  // main sequence
  // ****************
  initial begin
    logic [9:0] ix [8];
    logic [7:0] rv [8];
    int tk [4];
    int a, b, n;
    ix = '{`RTP_IDX_RUN, `RTP_IDX_OSC, `RTP_IDX_PIN, `RTP_IDX_MODE, `RTP_IDX_PRE, `RTP_IDX_SEC,
      `RTP_IDX_PRI, `RTP_IDX_ROUTE};
    rv = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h00, 8'hFF, 8'h00};
    tk = '{1, 8, 4, 2};
    repeat (12) @(posedge clk);
    resetn <= 1'h1;
    @(posedge clk);
    for (int i = 0; i < 8; i++) r8(ix[i], rv[i]);
    be <= 4'h0;
    w8(`RTP_IDX_PRE, 8'h12);
    be <= 4'hF;
    r8(`RTP_IDX_PRE, 8'hFF);
    w8(10'h100, 8'h5A);
    r8(10'h100, 8'h00);
    acc(1'h0, 12'h431, 8'h0, rv[0]);
    w8(`RTP_IDX_PIN, 8'hFF);
    r8(`RTP_IDX_PIN, 8'h0F);
    w8(`RTP_IDX_MODE, 8'hFF);
    r8(`RTP_IDX_MODE, 8'hBB);
    w8(`RTP_IDX_ROUTE, 8'hFF);
    r8(`RTP_IDX_ROUTE, 8'h23);
    w8(`RTP_IDX_PIN, 8'h00);
    // waveform on every count source, halted by force so the next mode change is legal
    for (int s = 0; s < 4; s++) begin
      rt <= s[0];
      w8(`RTP_IDX_ROUTE, {7'h0, s[0]});
      w8(`RTP_IDX_MODE, {2'h0, s[1:0], 4'h9});
      w8(`RTP_IDX_SEC, 8'h01);
      w8(`RTP_IDX_PRE, 8'h01);
      w8(`RTP_IDX_PRI, 8'h03);
      w8(`RTP_IDX_RUN, 8'h01);
      gap(n, 2000);
      gap(a, 2000);
      gap(b, 2000);
      chk("period", 8'(tk[s] * 12), 8'(a + b));
      chk("primary", 8'(tk[s] * 8), 8'(a > b ? a : b));
      w8(`RTP_IDX_RUN, 8'h04);
      r8(`RTP_IDX_RUN, 8'h00);
      r8(`RTP_IDX_PRE, 8'hFF);
      r8(`RTP_IDX_PRI, 8'hFF);
    end
    w8(`RTP_IDX_MODE, 8'h89);
    w8(`RTP_IDX_RUN, 8'h01);
    gap(n, 200);
    chk("gated", 8'hC8, 8'(n));
    w8(`RTP_IDX_RUN, 8'h04);
    w8(`RTP_IDX_MODE, 8'h00);
    w8(`RTP_IDX_PRE, 8'h00);
    w8(`RTP_IDX_PRI, 8'h05);
    r8(`RTP_IDX_PRI, 8'h05);
    w8(`RTP_IDX_RUN, 8'h01);
    r8(`RTP_IDX_RUN, 8'h03);
    w8(`RTP_IDX_OSC, 8'h01);
    r8(`RTP_IDX_OSC, 8'h00);
    w8(`RTP_IDX_RUN, 8'h00);
    r8(`RTP_IDX_RUN, 8'h00);
    w8(`RTP_IDX_MODE, 8'h0A);
    w8(`RTP_IDX_PRI, 8'h40);
    w8(`RTP_IDX_RUN, 8'h01);
    w8(`RTP_IDX_OSC, 8'h01);
    r8(`RTP_IDX_OSC, 8'h04);
    r8(`RTP_IDX_RUN, 8'h03);
    w8(`RTP_IDX_OSC, 8'h02);
    r8(`RTP_IDX_OSC, 8'h00);
    w8(`RTP_IDX_OSC, 8'h01);
    repeat (120) @(posedge clk);
    r8(`RTP_IDX_OSC, 8'h00);
    w8(`RTP_IDX_RUN, 8'h04);
    w8(`RTP_IDX_MODE, 8'h0B);
    w8(`RTP_IDX_SEC, 8'h20);
    w8(`RTP_IDX_PRI, 8'h20);
    w8(`RTP_IDX_RUN, 8'h01);
    w8(`RTP_IDX_OSC, 8'h01);
    r8(`RTP_IDX_OSC, 8'h04);
    w8(`RTP_IDX_RUN, 8'h04);
    r8(`RTP_IDX_OSC, 8'h00);
    end_sim();
  end
endmodule
`default_nettype wire
